// [logic/audio_serial_frame_decoder.sv]
/*
 * Receive decoder for three-wire serial audio in standard, left, right and
 * multiplexed framings, delivering words with channel numbers on clk.
 * Assumes the transmitter drives bit_clk, ws_pin and data_pin synchronously,
 * and that configuration only changes while enable is low.
 */
`timescale 1ns/1ps
`include "audio_serial_regs.svh"
module audio_serial_frame_decoder
   import audio_serial_pkg::*;
(
   input logic clk,
   input logic rst_n,
   input logic bit_clk,
   input logic ws_pin,
   input logic data_pin,
   input logic enable,
   input fmt_t fmt_sel,
   input logic lsb_first_order,
   input logic [`LEN_BITS-1:0] word_len,
   input logic [`LEN_BITS-1:0] chan_len,
   input logic [`LEN_BITS-1:0] chan_offset,
   input logic ws_inverted,
   input logic sample_on_fall,
   input logic overrun_clear,
   output logic [`WORD_BITS-1:0] word_data,
   output logic [`CHAN_BITS-1:0] word_chan,
   output logic word_valid,
   output logic cfg_error,
   output logic overrun,
   output logic running
);

   // ***********************************************
   // Configuration on the system clock
   // ***********************************************

   logic run_q, cfg_error_q, overrun_q;
   fmt_t fmt_q;
   logic lsb_q, inv_q, fall_q;
   logic [`LEN_BITS-1:0] wl_q, cl_q, off_q;
   logic cfg_bad;
   logic [`LEN_BITS:0] need_len;

   // Word plus used offset may not exceed the channel; bad settings never run.
   always_comb begin
      need_len = {1'b0, word_len};
      if (fmt_sel == FMT_LEFT || fmt_sel == FMT_TDM) begin
         need_len = {1'b0, word_len} + {1'b0, chan_offset};
      end
      cfg_bad = (word_len == `LEN_ZERO) || (chan_len == `LEN_ZERO) || (word_len > `LEN_FULL) ||
                (chan_len > `LEN_FULL) || (need_len > {1'b0, chan_len});
   end

   // Run request and the error flag follow the live settings.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 1'b0;
         cfg_error_q <= 1'b0;
      end else begin
         run_q <= enable && !cfg_bad;
         cfg_error_q <= cfg_bad;
      end
   end

   // Settings are frozen while running so the link side sees them static.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fmt_q <= FMT_STD;
         lsb_q <= 1'b0;
         inv_q <= 1'b0;
         fall_q <= 1'b0;
         wl_q <= `LEN_FULL;
         cl_q <= `LEN_FULL;
         off_q <= `LEN_ZERO;
      end else if (!run_q) begin
         fmt_q <= fmt_sel;
         lsb_q <= lsb_first_order;
         inv_q <= ws_inverted;
         fall_q <= sample_on_fall;
         wl_q <= word_len;
         cl_q <= chan_len;
         off_q <= chan_offset;
      end
   end

   chk_cfg_reject: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_error_q |-> !run_q)
      else $error("decoder running with rejected settings");

   // ***********************************************
   // Link clock, reset and run crossing
   // ***********************************************

   logic sample_clk;
   logic lrst1_q, lrst2_q, link_rst_n;
   logic run_m_q, run_l_q;

   // The selected bit clock edge becomes the rising edge of the link logic.
   assign sample_clk = bit_clk ^ fall_q;

   // Reset asserts at once and releases on the link clock.
   always_ff @(posedge sample_clk or negedge rst_n) begin
      if (!rst_n) begin
         lrst1_q <= 1'b0;
         lrst2_q <= 1'b0;
      end else begin
         lrst1_q <= 1'b1;
         lrst2_q <= lrst1_q;
      end
   end
   assign link_rst_n = lrst2_q;

   // Run level crosses through two flip-flops.
   always_ff @(posedge sample_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         run_m_q <= 1'b0;
         run_l_q <= 1'b0;
      end else begin
         run_m_q <= run_q;
         run_l_q <= run_m_q;
      end
   end

   // ***********************************************
   // Line sampling
   // ***********************************************

   logic ws_s_q, ws_d_q, dat_s_q, ws_prev_q;
   logic ws_lvl;

   // The three lines arrive as comparator levels; word select and data are
   // taken on the chosen edge, and word select once more for the delayed start.
   always_ff @(posedge sample_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ws_s_q <= 1'b0;
         ws_d_q <= 1'b0;
         dat_s_q <= 1'b0;
         ws_prev_q <= 1'b0;
      end else begin
         ws_s_q <= ws_pin;
         dat_s_q <= data_pin;
         ws_d_q <= ws_s_q;
         ws_prev_q <= ws_lvl;
      end
   end

   // Standard format sees word select one bit early, so its data starts a
   // period after the edge; polarity inversion applies to every format.
   assign ws_lvl = ((fmt_q == FMT_STD) ? ws_d_q : ws_s_q) ^ inv_q;

   // ***********************************************
   // Slot tracking and word capture
   // ***********************************************

   logic is_tdm, is_right;
   logic slot_start, wrap, block_start, synced_now, in_win, emit_v, busy;
   logic [`LEN_BITS-1:0] cur_pos, start, cap_base, cap_cnt_d;
   logic [`LEN_BITS:0] win_end;
   logic [`CHAN_BITS-1:0] cur_chan, emit_chan;
   logic [`WORD_BITS-1:0] sr_d, emit_word;
   logic [`LEN_BITS-1:0] pos_q, cap_cnt_q;
   logic [`CHAN_BITS-1:0] chan_q;
   logic [`WORD_BITS-1:0] sr_q;
   logic synced_q, ovr_tog_q;

   word_xfer_if x ();

   // Keeps the last word-length bits, aligned to bit 0 in either order.
   function automatic logic [`WORD_BITS-1:0] pick_word(input logic [`WORD_BITS-1:0] sr,
                                                       input logic [`LEN_BITS-1:0] wl,
                                                       input logic lsb);
      logic [`LEN_BITS-1:0] sh;
      sh = `LEN_FULL - wl;
      if (lsb) begin
         pick_word = sr >> sh;
      end else begin
         pick_word = sr & (`FULL_WORD >> sh);
      end
   endfunction

   assign is_tdm = (fmt_q == FMT_TDM);
   assign is_right = (fmt_q == FMT_RIGHT);
   assign busy = x.busy;

   // Slot boundaries: any level change in PCM formats, a rising pulse in
   // multiplexed mode, plus block wrap after each channel length.
   always_comb begin
      slot_start = is_tdm ? (ws_lvl && !ws_prev_q) : (ws_lvl != ws_prev_q);
      wrap = is_tdm && !slot_start && (pos_q == cl_q - `LEN_ONE);
      block_start = slot_start || wrap;
      synced_now = synced_q || slot_start;
      if (block_start) begin
         cur_pos = `LEN_ZERO;
      end else if (pos_q == `POS_SAT) begin
         cur_pos = `POS_SAT;
      end else begin
         cur_pos = pos_q + `LEN_ONE;
      end
      if (slot_start) begin
         cur_chan = is_tdm ? `CHAN_ZERO : {{(`CHAN_BITS-1){1'b0}}, ws_lvl};
      end else if (wrap) begin
         cur_chan = chan_q + `CHAN_ONE;
      end else begin
         cur_chan = chan_q;
      end
   end

   // Capture window: offset for left and multiplexed, at the edge for standard,
   // the whole slot for right justified where the tail is kept.
   always_comb begin
      start = (fmt_q == FMT_LEFT || is_tdm) ? off_q : `LEN_ZERO;
      win_end = {1'b0, start} + {1'b0, wl_q};
      in_win = is_right || (cur_pos >= start && {1'b0, cur_pos} < win_end);
      cap_base = block_start ? `LEN_ZERO : cap_cnt_q;
      cap_cnt_d = (in_win && cap_base < wl_q) ? cap_base + `LEN_ONE : cap_base;
      if (!in_win) begin
         sr_d = sr_q;
      end else if (lsb_q) begin
         sr_d = {dat_s_q, sr_q[`WORD_BITS-1:1]};
      end else begin
         sr_d = {sr_q[`WORD_BITS-2:0], dat_s_q};
      end
   end

   // A word completes at its last window bit, or for right justified at the
   // closing edge of a slot that supplied a full word.
   always_comb begin
      if (is_right) begin
         emit_v = run_l_q && slot_start && synced_q && (cap_cnt_q == wl_q);
         emit_word = pick_word(sr_q, wl_q, lsb_q);
         emit_chan = chan_q;
      end else begin
         emit_v = run_l_q && synced_now && in_win && ({1'b0, cur_pos} == win_end - 7'h01);
         emit_word = pick_word(sr_d, wl_q, lsb_q);
         emit_chan = cur_chan;
      end
   end

   // Position, channel and synchronisation state; cleared while not running.
   always_ff @(posedge sample_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         pos_q <= `LEN_ZERO;
         chan_q <= `CHAN_ZERO;
         synced_q <= 1'b0;
      end else if (!run_l_q) begin
         pos_q <= `LEN_ZERO;
         chan_q <= `CHAN_ZERO;
         synced_q <= 1'b0;
      end else begin
         pos_q <= cur_pos;
         chan_q <= cur_chan;
         synced_q <= synced_now;
      end
   end

   // Shift register and bit count of the word under capture.
   always_ff @(posedge sample_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sr_q <= `WORD_ZERO;
         cap_cnt_q <= `LEN_ZERO;
      end else if (!run_l_q) begin
         sr_q <= `WORD_ZERO;
         cap_cnt_q <= `LEN_ZERO;
      end else begin
         sr_q <= sr_d;
         cap_cnt_q <= cap_cnt_d;
      end
   end

   // Words that arrive while the crossing is busy are dropped and flagged by flipping a toggle.
   always_ff @(posedge sample_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ovr_tog_q <= 1'b0;
      end else if (emit_v && busy) begin
         ovr_tog_q <= ~ovr_tog_q;
      end
   end

   assign x.load = emit_v && !busy;
   assign x.data = emit_word;
   assign x.chan = emit_chan;

   cdc_word_sync u_sync (
      .link_clk(sample_clk),
      .link_rst_n(link_rst_n),
      .clk(clk),
      .rst_n(rst_n),
      .x(x.xfer)
   );

   // Link-side checks.
   // The pulse sense is judged from the pin itself, one and two samples back.
   chk_frame_restart: assert property (@(posedge sample_clk) disable iff (!link_rst_n)
      (run_l_q && is_tdm && slot_start) |=> (chan_q == `CHAN_ZERO) && (pos_q == `LEN_ZERO))
      else $error("frame pulse did not restart channel count");
   chk_pulse_sense: assert property (@(posedge sample_clk) disable iff (!link_rst_n)
      (run_l_q && is_tdm && slot_start) |-> ($past(ws_pin) != inv_q) && ($past(ws_pin, 2) == inv_q))
      else $error("frame pulse taken with wrong polarity");
   chk_word_bound: assert property (@(posedge sample_clk) disable iff (!link_rst_n)
      run_l_q |-> (cap_cnt_q <= wl_q))
      else $error("captured more bits than word length");
   chk_unused_zero: assert property (@(posedge sample_clk) disable iff (!link_rst_n)
      (emit_v && wl_q != `LEN_FULL) |-> ((emit_word >> wl_q) == `WORD_ZERO))
      else $error("word carries bits above word length");
   chk_offset_start: assert property (@(posedge sample_clk) disable iff (!link_rst_n)
      (run_l_q && fmt_q == FMT_LEFT && !block_start && off_q != `LEN_ZERO && cur_pos == off_q)
      |=> (cap_cnt_q == `LEN_ONE))
      else $error("capture did not begin at the offset");
   chk_pos_step: assert property (@(posedge sample_clk) disable iff (!link_rst_n)
      (run_l_q && !block_start && pos_q != `POS_SAT) |=> (pos_q == $past(pos_q) + `LEN_ONE))
      else $error("slot position did not advance per sample");

   // ***********************************************
   // Overrun flag on the system clock
   // ***********************************************

   logic ovr_m_q, ovr_s_q, ovr_seen_q;

   // A dropped word sets the flag; a set in the clearing cycle wins.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_m_q <= 1'b0;
         ovr_s_q <= 1'b0;
         ovr_seen_q <= 1'b0;
         overrun_q <= 1'b0;
      end else begin
         ovr_m_q <= ovr_tog_q;
         ovr_s_q <= ovr_m_q;
         ovr_seen_q <= ovr_s_q;
         if (ovr_s_q ^ ovr_seen_q) begin
            overrun_q <= 1'b1;
         end else if (overrun_clear) begin
            overrun_q <= 1'b0;
         end
      end
   end

   // Outputs come from the crossing and status flip-flops.
   assign word_data = x.out_data;
   assign word_chan = x.out_chan;
   assign word_valid = x.out_valid;
   assign cfg_error = cfg_error_q;
   assign overrun = overrun_q;
   assign running = run_q;

endmodule

// [logic/cdc_word_sync.sv]
/*
 * Toggle handshake that carries one word and its channel number across clocks.
 * Assumes the link side loads only while busy is low and holds config static.
 */
`timescale 1ns/1ps
`include "audio_serial_regs.svh"
module cdc_word_sync (
   input logic link_clk,
   input logic link_rst_n,
   input logic clk,
   input logic rst_n,
   word_xfer_if.xfer x
);

   logic req_tog_q;
   logic [`WORD_BITS-1:0] hold_data_q;
   logic [`CHAN_BITS-1:0] hold_chan_q;
   logic ack_m_q, ack_s_q;
   logic req_m_q, req_s_q, req_seen_q;
   logic out_valid_q;
   logic [`WORD_BITS-1:0] out_data_q;
   logic [`CHAN_BITS-1:0] out_chan_q;

   // ***********************************************
   // Link side
   // ***********************************************

   // A load captures the word and flips the request.
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         req_tog_q <= 1'b0;
         hold_data_q <= `WORD_ZERO;
         hold_chan_q <= `CHAN_ZERO;
      end else if (x.load) begin
         req_tog_q <= ~req_tog_q;
         hold_data_q <= x.data;
         hold_chan_q <= x.chan;
      end
   end

   // The acknowledge comes back through two flip-flops.
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ack_m_q <= 1'b0;
         ack_s_q <= 1'b0;
      end else begin
         ack_m_q <= req_seen_q;
         ack_s_q <= ack_m_q;
      end
   end

   // Busy while a request has not yet been acknowledged.
   assign x.busy = req_tog_q ^ ack_s_q;

   // ***********************************************
   // System side
   // ***********************************************

   // The request is synchronised, then the held word is taken once.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_m_q <= 1'b0;
         req_s_q <= 1'b0;
         req_seen_q <= 1'b0;
         out_valid_q <= 1'b0;
         out_data_q <= `WORD_ZERO;
         out_chan_q <= `CHAN_ZERO;
      end else begin
         req_m_q <= req_tog_q;
         req_s_q <= req_m_q;
         req_seen_q <= req_s_q;
         out_valid_q <= req_s_q ^ req_seen_q;
         if (req_s_q ^ req_seen_q) begin
            out_data_q <= hold_data_q;
            out_chan_q <= hold_chan_q;
         end
      end
   end

   assign x.out_valid = out_valid_q;
   assign x.out_data = out_data_q;
   assign x.out_chan = out_chan_q;

   // Checks on the crossing itself.
   chk_busy_bound: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $rose(x.busy) |-> ##[1:20] !x.busy)
      else $error("word crossing stayed busy too long");
   chk_load_idle: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      x.load |-> !x.busy)
      else $error("word loaded while crossing busy");
   chk_out_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      out_valid_q |=> !out_valid_q)
      else $error("word valid longer than one cycle");

endmodule

// [pkg/audio_serial_pkg.sv]
/*
 * Types of the serial audio frame decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package audio_serial_pkg;

   // Frame formats that the decoder understands.
   typedef enum logic [1:0] {
      FMT_STD,
      FMT_LEFT,
      FMT_RIGHT,
      FMT_TDM
   } fmt_t;

endpackage

// [pkg/audio_serial_regs.svh]
/*
 * Constants of the serial audio frame decoder: widths, limits and fixed values.
 * Assumes it is included by its bare name from the pkg folder on the include path.
 */
//
// Overview of operation
// - Link uses exactly three lines: bit clock, word select, data.
// - In multiplexed mode a word select pulse starts a new frame.
// - Only word bits are captured, except right justified which shifts in the whole slot and keeps its tail; remaining slot bits are discarded.
// - Words assemble most or least significant bit first, as configured.
// - Left justified words may start a configured offset after the edge.
// - Channel length must be at least word length, plus offset in left and multiplexed; else rejected.
// - Each line enters as a thresholded logic level before decoding.
// - Word select polarity may be normal or inverted.
`ifndef AUDIO_SERIAL_REGS_SVH
`define AUDIO_SERIAL_REGS_SVH

`define WORD_BITS 32
`define LEN_BITS 6
`define CHAN_BITS 4
`define FULL_WORD 32'hffffffff
`define WORD_ZERO 32'h00000000
`define LEN_FULL 6'h20
`define LEN_ZERO 6'h00
`define LEN_ONE 6'h01
`define POS_SAT 6'h3f
`define CHAN_ZERO 4'h0
`define CHAN_ONE 4'h1

`endif

// [pkg/word_xfer_if.sv]
/*
 * Carrier for decoded words passing from the link domain to the system domain.
 * Assumes the link side loads only while busy is low.
 */
`timescale 1ns/1ps
`include "audio_serial_regs.svh"
interface word_xfer_if;
   logic load;
   logic [`WORD_BITS-1:0] data;
   logic [`CHAN_BITS-1:0] chan;
   logic busy;
   logic out_valid;
   logic [`WORD_BITS-1:0] out_data;
   logic [`CHAN_BITS-1:0] out_chan;

   modport src (output load, output data, output chan, input busy,
                input out_valid, input out_data, input out_chan);
   modport xfer (input load, input data, input chan, output busy,
                 output out_valid, output out_data, output out_chan);
endinterface

// [tb/audio_tx_model.sv]
/*
 * Behavioural serial audio transmitter driving bit clock, word select and data.
 * Assumes the bench fills the bit queues and calls play; the clock is still between streams.
 */
`timescale 1ns/1ps
module audio_tx_model (
   output logic bit_clk,
   output logic ws_pin,
   output logic data_pin
);
   bit ws_q[$];
   bit dat_q[$];

   // Lines start quiet with the clock low.
   initial begin
      bit_clk = 1'b0;
      ws_pin = 1'b0;
      data_pin = 1'b0;
   end

   // Parks the clock so that its next edge is the chosen sample edge.
   task automatic park(input bit fall);
      bit_clk = fall;
   endtask

   // Sends the queued bits on three lines, each changing half a period before the sample edge.
   task automatic play();
      while (ws_q.size() > 0) begin
         ws_pin = ws_q.pop_front();
         data_pin = dat_q.pop_front();
         #6 bit_clk = ~bit_clk;
         #6 bit_clk = ~bit_clk;
      end
      // A released data line must not keep showing its last bit.
      data_pin = ~data_pin;
   endtask
endmodule

// [tb/tb.sv]
/*
 * Self-checking bench of the serial audio frame decoder with a transmitter model.
 * Assumes the design package, the constants header and tb/audio_tx_model.sv.
 */
`timescale 1ns/1ps
`include "audio_serial_regs.svh"
`define CHECK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin errors++; \
   $display("Error at %0t: %s", $time, msg); end end
module tb
   import audio_serial_pkg::*;
;
   logic clk, rst_n, bit_clk, ws_pin, data_pin, enable, lsb_first_order;
   logic ws_inverted, sample_on_fall, overrun_clear, word_valid, cfg_error, overrun, running;
   fmt_t fmt_sel;
   logic [`LEN_BITS-1:0] word_len, chan_len, chan_offset;
   logic [`WORD_BITS-1:0] word_data;
   logic [`CHAN_BITS-1:0] word_chan;
   logic [`CHAN_BITS+`WORD_BITS-1:0] exp_q[$];
   int errors, total_checks;

   audio_serial_frame_decoder dut (.clk(clk), .rst_n(rst_n), .bit_clk(bit_clk), .ws_pin(ws_pin),
      .data_pin(data_pin), .enable(enable), .fmt_sel(fmt_sel), .lsb_first_order(lsb_first_order),
      .word_len(word_len), .chan_len(chan_len), .chan_offset(chan_offset), .ws_inverted(ws_inverted),
      .sample_on_fall(sample_on_fall), .overrun_clear(overrun_clear), .word_data(word_data),
      .word_chan(word_chan), .word_valid(word_valid), .cfg_error(cfg_error), .overrun(overrun),
      .running(running));
   audio_tx_model tx (.bit_clk(bit_clk), .ws_pin(ws_pin), .data_pin(data_pin));

   // ***************************************
   // Clock, monitor and verdict
   // ***************************************

   // System clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Each delivered word must be the next expected one, and none may be dropped.
   always @(posedge clk) begin
      if (word_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHECK(1'b1, 1'b0, "unexpected word")
         end else begin
            `CHECK({word_chan, word_data}, exp_q.pop_front(), "word or channel")
         end
         `CHECK(overrun, 1'b0, "word dropped")
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("Checks made: %0d, mismatches: %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      #1000000;
      errors++;
      $display("Error at %0t: timeout", $time);
      print_verdict();
   end

   // ***************************************
   // Stream building
   // ***************************************

   // Queues one bit time; word select goes out in the configured sense.
   task automatic put(input bit w, input bit inv, input bit d);
      tx.ws_q.push_back(w ^ inv);
      tx.dat_q.push_back(d);
   endtask

   // Queues k bit times at the level the word select pin shows now.
   task automatic hold(input int k);
      repeat (k) begin
         tx.ws_q.push_back(tx.ws_pin);
         tx.dat_q.push_back(1'($urandom_range(1)));
      end
   endtask

   // Applies settings while idle, checks them, then sends n slots or blocks and awaits the words.
   task automatic run(input fmt_t f, input bit lsb, input int wl, input int cl, input int off,
                      input bit inv, input bit fall, input int n, input bit good);
      logic [`WORD_BITS-1:0] v;
      int p;
      bit w;
      @(posedge clk);
      enable <= 1'b0;
      overrun_clear <= 1'b1;
      repeat (3) @(posedge clk);
      fmt_sel <= f;
      lsb_first_order <= lsb;
      word_len <= 6'(wl);
      chan_len <= 6'(cl);
      chan_offset <= 6'(off);
      ws_inverted <= inv;
      sample_on_fall <= fall;
      tx.park(fall);
      @(posedge clk);
      enable <= 1'b1;
      overrun_clear <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHECK(running, good, "running state")
      `CHECK(cfg_error, ~good, "settings check")
      // Lead-in: four bits at the standing level, then two opposite the first slot, so the
      // link side arms and no early slot is long enough to complete a word.
      hold(4);
      for (int i = 0; i < 2; i++) put(f != FMT_TDM, inv, 1'($urandom_range(1)));
      for (int s = 0; s < n; s++) begin
         v = 32'($urandom) & 32'((64'h1 << wl) - 1);
         case (f)
            FMT_STD: p = 1;
            FMT_RIGHT: p = cl - wl;
            default: p = off;
         endcase
         if (good) exp_q.push_back({f == FMT_TDM ? 4'(s) : {3'h0, 1'(s)}, v});
         for (int i = 0; i < cl; i++) begin
            w = (f == FMT_TDM) ? (s == 0 && i == 0) : 1'(s);
            put(w, inv, (i >= p && i < p + wl) ? (lsb ? v[i - p] : v[wl - 1 - i + p])
                : 1'($urandom_range(1)));
         end
      end
      // Two tail bits finish the last word; only right justified changes level to close its slot.
      for (int i = 0; i < 2; i++) put((f == FMT_RIGHT) ? n % 2 == 1 : (f != FMT_TDM && n % 2 == 0), inv,
                                      1'($urandom_range(1)));
      tx.play();
      for (int k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge clk);
      `CHECK(exp_q.size(), 0, "words missing")
      exp_q.delete();
      // Disarm, then clock steady bits so the link side sees the stop before new settings.
      @(posedge clk);
      enable <= 1'b0;
      repeat (2) @(posedge clk);
      hold(3);
      tx.play();
   endtask

   // Reset, corner cases, refused settings, then random mixes.
   initial begin
      int wl, cl, off;
      fmt_t f;
      rst_n = 1'b0;
      enable = 1'b0;
      fmt_sel = FMT_STD;
      lsb_first_order = 1'b0;
      word_len = `LEN_FULL;
      chan_len = `LEN_FULL;
      chan_offset = `LEN_ZERO;
      ws_inverted = 1'b0;
      sample_on_fall = 1'b0;
      overrun_clear = 1'b0;
      errors = 0;
      total_checks = 0;
      void'($urandom(88));
      for (int i = 0; i < 4; i++) put(1'b0, 1'b0, 1'b0);
      fork
         tx.play();
      join_none
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      run(FMT_STD, 1'b0, 24, 32, 0, 1'b0, 1'b0, 4, 1'b1);
      run(FMT_STD, 1'b1, 16, 32, 0, 1'b1, 1'b0, 3, 1'b1);
      run(FMT_STD, 1'b0, 20, 24, 10, 1'b0, 1'b0, 2, 1'b1);
      run(FMT_LEFT, 1'b0, 32, 32, 0, 1'b0, 1'b0, 3, 1'b1);
      run(FMT_LEFT, 1'b1, 8, 16, 5, 1'b0, 1'b1, 3, 1'b1);
      run(FMT_RIGHT, 1'b0, 16, 32, 0, 1'b0, 1'b0, 4, 1'b1);
      run(FMT_RIGHT, 1'b1, 5, 8, 0, 1'b1, 1'b1, 4, 1'b1);
      run(FMT_TDM, 1'b0, 12, 16, 2, 1'b1, 1'b0, 5, 1'b1);
      run(FMT_TDM, 1'b1, 8, 8, 0, 1'b0, 1'b1, 17, 1'b1);
      run(FMT_LEFT, 1'b0, 20, 24, 5, 1'b0, 1'b0, 2, 1'b0);
      run(FMT_TDM, 1'b0, 0, 16, 0, 1'b0, 1'b0, 2, 1'b0);
      run(FMT_STD, 1'b0, 8, 33, 0, 1'b0, 1'b0, 2, 1'b0);
      run(FMT_RIGHT, 1'b0, 9, 8, 0, 1'b0, 1'b0, 2, 1'b0);
      for (int t = 0; t < 24; t++) begin
         f = fmt_t'($urandom_range(3));
         cl = $urandom_range(32, 9);
         off = $urandom_range(3);
         wl = $urandom_range(cl - off - 1, 5);
         run(f, 1'($urandom_range(1)), wl, cl, off, 1'($urandom_range(1)), 1'($urandom_range(1)),
             $urandom_range(4, 2), 1'b1);
      end
      print_verdict();
   end
endmodule
